/* design/wsup_pkg.sv */
package wsup_pkg;
    // Counter and register widths
    localparam int              CTR_W          = 7;
    localparam int              PRE_W          = 14;
    // Reset values of control and window registers
    localparam logic [6:0]      CTRL_RST       = 7'h7f;
    localparam logic [6:0]      WIN_RST        = 7'h7f;
    // Control write field positions
    localparam int              ACT_POS        = 7;
    localparam int              TOP_POS        = 6;
    // Prescaler period in source clock cycles
    localparam int              PRE_PERIOD     = 16384;
    localparam logic [13:0]     PRE_LAST       = 14'(PRE_PERIOD - 1);
    // Clock rate and reset pulse length
    localparam int              CLK_MHZ        = 25;
    localparam int              RST_PULSE_NS   = 30000;
    localparam int              RST_CYC        = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;
    localparam logic [9:0]      RST_LAST       = 10'(RST_CYC - 1);
    // Restart delays after wake-up, in CPU clocks
    localparam logic [11:0]     WAKE_SHORT     = 12'h0ff;
    localparam logic [11:0]     WAKE_LONG      = 12'hfff;
    // Counter threshold where top bit clears
    localparam logic [6:0]      TOP_EDGE       = 7'h40;
endpackage : wsup_pkg

/* design/wsup_pulse.sv */
`timescale 1ns/1ps
`default_nettype none
// Stretches a one-cycle trigger into a fixed low pulse on the reset line
module wsup_pulse (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst,
    // Trigger and output
    input  wire logic       trig,
    output logic            rst_n_out
);
    import wsup_pkg::*;

    typedef struct packed {
        logic       busy;   // Pulse in progress
        logic [9:0] elapsed; // Cycles since pulse start
        logic       outn;   // Registered reset line level
    } wsup_pul_s;
    wsup_pul_s q, d;

    // Next state: start on trigger, hold low for RST_CYC cycles
    always_comb begin
        d = q;
        if (q.busy) begin
            if (q.elapsed == RST_LAST) begin
                d.busy = 1'b0;
                d.outn = 1'b1;
            end else begin
                d.elapsed = q.elapsed + 10'h001;
            end
        end else if (trig) begin
            d.busy = 1'b1;
            d.elapsed = 10'h000;
            d.outn = 1'b0;
        end
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            q <= '{busy: 1'b0, elapsed: 10'h000, outn: 1'b1};
        end else begin
            q <= d;
        end
    end

    assign rst_n_out = q.outn;

    chk_pulse_len: assert property (@(posedge clk) disable iff (rst)
        $rose(q.busy) |-> (!q.outn) [*8] ##0 (q.busy))
        else $error("reset pulse ended early");
endmodule : wsup_pulse
`default_nettype wire

/* design/wsup_top.sv */
`timescale 1ns/1ps
`default_nettype none
module wsup_top (
    // Clock and reset
    input  wire logic       REF_CLK,
    input  wire logic       RESET,
    // Source clock enable for the prescaler
    input  wire logic       SRC_CLK_EN,
    // Option straps
    input  wire logic       HW_ACTIVE_OPT,
    input  wire logic       RESET_ON_HALT_OPT,
    // Control register write port
    input  wire logic       CTRL_WR,
    input  wire logic [7:0] CTRL_WDATA,
    // Window register write port
    input  wire logic       WIN_WR,
    input  wire logic [6:0] WIN_WDATA,
    // CPU power state events
    input  wire logic       HALT_ENTER,
    input  wire logic       ACT_HALT_ENTER,
    input  wire logic       WAKE_IRQ,
    input  wire logic       WAKE_LONG_SEL,
    // Register readback
    output logic [7:0]      CTRL_RDATA,
    output logic [6:0]      WIN_RDATA,
    // Chip reset line, active low
    output logic            CHIP_RESET_N,
    // Halt allowed to proceed
    output logic            HALT_GRANT
);
    import wsup_pkg::*;

    typedef enum logic [1:0] {WS_RUN, WS_HALT_LAST, WS_STOP, WS_WAKE} wsup_mode_e;

    typedef struct packed {
        logic [13:0] pre;       // Prescaler phase
        logic [6:0]  step_count;// Downcounter
        logic [6:0]  win;       // Window value
        logic        act;       // Software activation
        wsup_mode_e  mode;      // Power mode tracking
        logic        act_halt;  // Stopped by active halt
        logic [11:0] wake;      // Restart delay counter
        logic        trig;      // Reset trigger this cycle
        logic        grant;     // Halt granted
        logic [7:0]  rd_ctrl;   // Control readback register
        logic [6:0]  rd_win;    // Window readback register
        logic        rd_grant;  // Registered halt grant output
    } wsup_s;
    wsup_s q, d;

    logic active;       // Watchdog able to reset
    logic tick;         // Prescaler period end
    logic counting;     // Counter allowed to decrement
    logic trig_pre;     // Pending reset trigger
    logic rst_n_w;      // Pulse stretcher output

    assign active   = HW_ACTIVE_OPT | q.act;
    assign tick     = SRC_CLK_EN && (q.pre == PRE_LAST);
    assign counting = (q.mode == WS_RUN) || (q.mode == WS_HALT_LAST);

    // Next state of the whole watchdog
    always_comb begin
        d        = q;
        trig_pre = 1'b0;
        d.grant  = 1'b0;
        // Prescaler runs freely, writes never touch its phase
        if (SRC_CLK_EN) begin
            d.pre = q.pre + 14'h0001;
        end
        // Decrement on each tick while counting, regardless of enable
        if (tick && counting) begin
            d.step_count = q.step_count - 7'h01;
            if (q.step_count == TOP_EDGE && active) begin
                trig_pre = 1'b1;
            end
            if (q.mode == WS_HALT_LAST) begin
                d.mode = WS_STOP;
            end
        end
        // Window write used by later checks and by the window readback
        if (WIN_WR) begin
            d.win = WIN_WDATA;
        end
        // Control write: window check on the old counter value
        if (CTRL_WR) begin
            if (CTRL_WDATA[ACT_POS]) begin
                d.act = 1'b1;
            end
            if ((HW_ACTIVE_OPT | CTRL_WDATA[ACT_POS] | q.act) && !CTRL_WDATA[TOP_POS]) begin
                trig_pre = 1'b1;
            end
            if (active && (q.step_count > q.win)) begin
                trig_pre = 1'b1;
            end
            d.step_count = CTRL_WDATA[6:0];
        end
        // Power mode sequencing
        unique case (q.mode)
            WS_RUN: begin
                if (HALT_ENTER) begin
                    if (active && RESET_ON_HALT_OPT) begin
                        trig_pre = 1'b1;
                    end else begin
                        d.mode    = WS_HALT_LAST;
                        d.grant   = 1'b1;
                    end
                end else if (ACT_HALT_ENTER) begin
                    d.mode     = WS_STOP;
                    d.act_halt = 1'b1;
                    d.grant    = 1'b1;
                end
            end
            WS_HALT_LAST: begin
                if (WAKE_IRQ) begin
                    d.mode = WS_WAKE;
                    d.wake = WAKE_LONG_SEL ? WAKE_LONG : WAKE_SHORT;
                end
            end
            WS_STOP: begin
                if (WAKE_IRQ) begin
                    if (q.act_halt) begin
                        d.mode = WS_RUN;
                    end else begin
                        d.mode = WS_WAKE;
                        d.wake = WAKE_LONG_SEL ? WAKE_LONG : WAKE_SHORT;
                    end
                    d.act_halt = 1'b0;
                end
            end
            WS_WAKE: begin
                if (q.wake == 12'h000) begin
                    d.mode = WS_RUN;
                end else begin
                    d.wake = q.wake - 12'h001;
                end
            end
        endcase
        d.trig = trig_pre;
        // Readback and grant outputs lag the state by one cycle
        d.rd_ctrl  = {q.act, q.step_count};
        d.rd_win   = q.win;
        d.rd_grant = q.grant;
    end

    // State register with documented reset values
    always_ff @(posedge REF_CLK) begin
        if (RESET) begin
            q <= '{pre: 14'h0000, step_count: CTRL_RST, win: WIN_RST, act: 1'b0,
                   mode: WS_RUN, act_halt: 1'b0, wake: 12'h000, trig: 1'b0, grant: 1'b0,
                   rd_ctrl: {1'b0, CTRL_RST}, rd_win: WIN_RST, rd_grant: 1'b0};
        end else begin
            q <= d;
        end
    end

    // Reset pulse generator
    wsup_pulse u_pulse (
        .clk       (REF_CLK),
        .rst       (RESET),
        .trig      (q.trig),
        .rst_n_out (rst_n_w)
    );

    // Outputs straight from registers: readback and grant from the state register, reset line from the pulse stretcher
    assign CTRL_RDATA   = q.rd_ctrl;
    assign WIN_RDATA    = q.rd_win;
    assign HALT_GRANT   = q.rd_grant;
    assign CHIP_RESET_N = rst_n_w;

    // Checks
    sequence s_edge_step;
        tick && counting && !CTRL_WR && q.step_count == TOP_EDGE && active;
    endsequence
    chk_edge_reset: assert property (@(posedge REF_CLK) disable iff (RESET)
        s_edge_step |=> q.trig ##1 !CHIP_RESET_N)
        else $error("no reset at top bit clear");
    chk_early_refresh: assert property (@(posedge REF_CLK) disable iff (RESET)
        (CTRL_WR && active && q.step_count > q.win) |=> q.trig)
        else $error("early refresh not reset");
    chk_soft_reset: assert property (@(posedge REF_CLK) disable iff (RESET)
        (CTRL_WR && CTRL_WDATA[ACT_POS] && !CTRL_WDATA[TOP_POS]) |=> q.trig)
        else $error("software reset missing");
    chk_act_sticky: assert property (@(posedge REF_CLK) disable iff (RESET)
        q.act |=> q.act)
        else $error("activation cleared without reset");
    chk_no_reset_idle: assert property (@(posedge REF_CLK) disable iff (RESET)
        (!active && !CTRL_WR && !HALT_ENTER) |=> !q.trig)
        else $error("reset while disabled");
    chk_free_count: assert property (@(posedge REF_CLK) disable iff (RESET)
        (tick && q.mode == WS_RUN && !CTRL_WR) |=> q.step_count == $past(q.step_count) - 7'h01)
        else $error("counter did not decrement");
    chk_stop_hold: assert property (@(posedge REF_CLK) disable iff (RESET)
        (q.mode == WS_STOP && !CTRL_WR) |=> q.step_count == $past(q.step_count))
        else $error("counter moved while stopped");
    chk_halt_reset: assert property (@(posedge REF_CLK) disable iff (RESET)
        (q.mode == WS_RUN && HALT_ENTER && active && RESET_ON_HALT_OPT) |=> q.trig && !q.grant)
        else $error("halt did not reset");
    chk_window_load: assert property (@(posedge REF_CLK) disable iff (RESET)
        WIN_WR |=> q.win == $past(WIN_WDATA))
        else $error("window not loaded");
endmodule : wsup_top
`default_nettype wire

/* tb/wsup_rst_mon.sv */
`timescale 1ns/1ps
`default_nettype none
// Chip reset circuitry: measures each low pulse on the reset line
module wsup_rst_mon (
    // Clock and watched line
    input  wire logic clk,
    input  wire logic rst_n,
    // Length of last finished pulse
    output var  int   last_len
);
    int run_len; // Cycles low so far
    initial begin
        run_len  = 0;
        last_len = 0;
    end
    // Count low cycles, latch the length on release
    always @(posedge clk) begin
        if (rst_n === 1'b0) begin
            run_len <= run_len + 1;
        end else if (run_len != 0) begin
            last_len <= run_len;
            run_len  <= 0;
        end
    end
endmodule : wsup_rst_mon
`default_nettype wire

/* tb/tb_window_watchdog.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_window_watchdog;
    import wsup_pkg::*;
    logic       ref_clk, reset, src_en, hw_opt, halt_opt, ctrl_wr, win_wr;
    logic       halt_in, act_halt, wake, wake_long, chip_reset_n, halt_grant;
    logic [7:0] ctrl_wdata, ctrl_rdata;
    logic [6:0] win_wdata, win_rdata;
    int         failures, check_count, mon_len;
    // Design under test
    wsup_top dut (.REF_CLK(ref_clk), .RESET(reset), .SRC_CLK_EN(src_en), .HW_ACTIVE_OPT(hw_opt),
        .RESET_ON_HALT_OPT(halt_opt), .CTRL_WR(ctrl_wr), .CTRL_WDATA(ctrl_wdata), .WIN_WR(win_wr),
        .WIN_WDATA(win_wdata), .HALT_ENTER(halt_in), .ACT_HALT_ENTER(act_halt), .WAKE_IRQ(wake),
        .WAKE_LONG_SEL(wake_long), .CTRL_RDATA(ctrl_rdata), .WIN_RDATA(win_rdata),
        .CHIP_RESET_N(chip_reset_n), .HALT_GRANT(halt_grant));
    // Reset circuitry model
    wsup_rst_mon mon (.clk(ref_clk), .rst_n(chip_reset_n), .last_len(mon_len));
    // 25 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    task automatic complete_run();
        if (failures == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : complete_run
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
            failures++;
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(negedge ref_clk);
    endtask : tick
    // Block reset, also after each chip reset pulse except the last one
    task automatic do_reset(input logic hw);
        reset  = 1'b1;
        hw_opt = hw;
        tick(5);
        reset = 1'b0;
    endtask : do_reset
    task automatic ctrl_write(input logic [7:0] d);
        ctrl_wr    = 1'b1;
        ctrl_wdata = d;
        tick(1);
        ctrl_wr = 1'b0;
        tick(1); // Idle cycle between writes
    endtask : ctrl_write
    // Bounded wait for a reset pulse, then measure it
    task automatic expect_pulse(input int bound);
        int n;
        n = 0;
        while (chip_reset_n !== 1'b0 && n < bound) begin
            tick(1);
            n++;
        end
        check("reset_seen", 16'h0, {15'h0, chip_reset_n});
        if (chip_reset_n !== 1'b0) complete_run();
        while (chip_reset_n !== 1'b1 && n < bound + 800) begin
            tick(1);
            n++;
        end
        check("pulse_end", 16'h1, {15'h0, chip_reset_n});
        if (chip_reset_n !== 1'b1) complete_run();
        tick(2);
        check("pulse_len", 16'(RST_CYC), 16'(mon_len));
    endtask : expect_pulse
    // Line must stay high for n cycles
    task automatic expect_none(input int n);
        repeat (n) begin
            tick(1);
            if (chip_reset_n !== 1'b1) check("no_reset", 16'h1, {15'h0, chip_reset_n});
        end
    endtask : expect_none
    task automatic t_window();
        do_reset(1'b0);
        check("ctrl_rst", 16'h7f, {8'h0, ctrl_rdata});
        check("win_rst", 16'h7f, {9'h0, win_rdata});
        ctrl_write(8'hff);
        tick(2);
        check("ctrl_rd", 16'hff, {8'h0, ctrl_rdata});
        ctrl_write(8'he0);
        ctrl_write(8'hff);
        check("ctrl_refresh", 16'hff, {8'h0, ctrl_rdata});
        expect_none(4);
        win_wr    = 1'b1;
        win_wdata = 7'h50;
        tick(1);
        win_wr = 1'b0;
        tick(2);
        check("win_rd", 16'h50, {9'h0, win_rdata});
        ctrl_write(8'hff);
        expect_pulse(4);
    endtask : t_window
    task automatic t_soft();
        do_reset(1'b0);
        ctrl_write(8'h3f);
        expect_none(4);
        check("ctrl_ld", 16'h3f, {8'h0, ctrl_rdata});
        ctrl_write(8'hbf);
        expect_pulse(4);
        do_reset(1'b1);
        ctrl_write(8'h3f);
        expect_pulse(4);
    endtask : t_soft
    task automatic t_halt();
        int n;
        do_reset(1'b0);
        halt_opt = 1'b1;
        ctrl_write(8'hff);
        halt_in = 1'b1;
        tick(1);
        halt_in = 1'b0;
        expect_pulse(4);
        do_reset(1'b0);
        halt_opt = 1'b0;
        ctrl_write(8'hff);
        halt_in = 1'b1;
        tick(1);
        halt_in = 1'b0;
        n = 0;
        while (halt_grant !== 1'b1 && n < 3) begin
            tick(1);
            n++;
        end
        check("halt_grant", 16'h1, {15'h0, halt_grant});
        wake = 1'b1;
        tick(1);
        wake = 1'b0;
        expect_none(4);
    endtask : t_halt
    // Active halt freezes the counter, a wake resumes it at once
    task automatic t_act_halt();
        do_reset(1'b0);
        ctrl_write(8'hc0);
        act_halt = 1'b1;
        tick(1);
        act_halt = 1'b0;
        tick(1);
        check("act_grant", 16'h1, {15'h0, halt_grant});
        expect_none(PRE_PERIOD + 8);
        check("act_hold", 16'hc0, {8'h0, ctrl_rdata});
        wake = 1'b1;
        tick(1);
        wake = 1'b0;
        expect_pulse(PRE_PERIOD + 8);
    endtask : t_act_halt
    task automatic t_count();
        int n;
        do_reset(1'b0);
        ctrl_write(8'h41);
        n = 0;
        while (ctrl_rdata[6:0] !== 7'h3f && n < 2 * PRE_PERIOD + 8) begin
            tick(1);
            n++;
        end
        check("free_run", 16'h3f, {9'h0, ctrl_rdata[6:0]});
        check("no_rst_off", 16'h1, {15'h0, chip_reset_n});
        do_reset(1'b0);
        ctrl_write(8'hc0);
        expect_pulse(PRE_PERIOD + 4);
    endtask : t_count
    initial begin
        failures = 0;
        check_count = 0;
        {reset, hw_opt, halt_opt, ctrl_wr, win_wr, halt_in, act_halt, wake, wake_long} = '0;
        src_en     = 1'b1;
        ctrl_wdata = 8'hff;
        win_wdata  = 7'h7f;
        t_window();
        t_soft();
        t_halt();
        t_act_halt();
        t_count();
        complete_run();
    end
endmodule : tb_window_watchdog
`default_nettype wire
